// ==== shared/hs_ctrl_defines.svh ====
// Purpose: constants for the hot swap command and status block
// Assumes: 20 MHz pclk, APB with 32-bit words
// Notes: offsets are byte addresses
`ifndef HS_CTRL_DEFINES_SVH
`define HS_CTRL_DEFINES_SVH
`define A_OPERATION 12'h000
`define A_RESTART 12'h004
`define A_CLEAR 12'h008
`define A_STAT_BYTE 12'h00c
`define A_STAT_WORD 12'h010
`define A_STAT_INPUT 12'h014
`define A_STAT_VOUT 12'h018
`define A_STAT_IOUT 12'h01c
`define A_STAT_TEMP 12'h020
`define A_STAT_MFR 12'h024
`define A_SETUP 12'h028
`define A_MASK1 12'h02c
`define A_MASK2 12'h030
`define A_CAPABILITY 12'h034
`define A_ID_IDX 12'h038
`define A_ID_DATA 12'h03c
`define A_COMM 12'h040
`define A_CMD_FRAME 12'h044
`define ON_BIT 7
`define ON_RESET 8'h80
`define RESTART_SEC 10
`define CLK_HZ 20000000
`define CAPABILITY_VAL 8'hb0
`define MODE_GPO 2'h0
`define MODE_ALERT 2'h1
`define MODE_CMP 2'h2
`define ID_LEN 8'h04
`define PIN_IDLE 3'h1
`define FR_PEC 8
`define FR_GROUP 9
`define FR_STOP 10
`define FR_RST 11
`endif

// ==== shared/hs_ctrl_pkg.sv ====
// Purpose: types for the hot swap command and status block
// Assumes: nothing beyond the defines header
// Notes: status vectors are grouped as one struct
package hs_ctrl_pkg;
	// latched fault / warning sources
	typedef struct packed {
		logic cl_timeout;
		logic ov_fault;
		logic uv_fault;
		logic ot_fault;
		logic fet_fault;
		logic vin_ov_warn;
		logic vin_uv_warn;
		logic vout_ov_warn;
		logic vout_uv_warn;
		logic iout_oc_warn;
		logic ot_warn;
		logic pin_op_warn;
		logic comm_err;
	} stat_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_OFF = 3'b010,
		ST_DONE = 3'b100
	} restart_t;
endpackage : hs_ctrl_pkg

// ==== testbench/bus_host.sv ====
// Purpose: bus host model on APB
// Assumes: pready sampled at rising edges
// Notes: a wait gives up after 64 edges
`timescale 1ns/1ps
module bus_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	logic hung = 1'b0;
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// one transfer, held until pready
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (!pready && n < 64);
		hung = !pready;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // stale data must not look valid
	endtask : xfer
endmodule : bus_host

// ==== testbench/hs_ctrl_assertions.sv ====
// Purpose: port checks for hs_ctrl
// Assumes: pins reach the drive within 4 edges
// Notes: bound after the module
`timescale 1ns/1ps
`include "hs_ctrl_defines.svh"
module hs_ctrl_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic input_level_ok_pin,
	input wire logic high_input_limit_pin,
	input wire hs_ctrl_pkg::stat_t cond_in,
	input wire logic fet_drive_out,
	input wire logic latched_trip_pin
);
	import hs_ctrl_pkg::*;
	// one domain, clocking given once
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// write taken at this edge
	wire wr_x = psel && penable && pwrite;
	chk_low_off: assert property (!input_level_ok_pin [*5] |-> !fet_drive_out) else $error("drive on, supply low");
	chk_high_off: assert property (high_input_limit_pin [*5] |-> !fet_drive_out) else $error("drive on, over limit");
	chk_cmd_off: assert property (wr_x && paddr == `A_OPERATION && !pwdata[7] |=> ##1 !fet_drive_out) else $error("off cmd");
	chk_fault_act: assert property (cond_in.uv_fault [*5] |-> latched_trip_pin && !fet_drive_out) else $error("fault");
	chk_trip_hold: assert property (latched_trip_pin && !wr_x && !$past(wr_x) && !$past(wr_x, 2) |=> latched_trip_pin) else $error("trip lost");
	chk_restart_off: assert property (wr_x && paddr == `A_RESTART |=> ##1 !fet_drive_out) else $error("restart");
	chk_ready: assert property (psel |-> pready) else $error("no ready");
	chk_unmapped: assert property (psel && penable && paddr > `A_CMD_FRAME |-> pslverr) else $error("no error");
endmodule : hs_ctrl_chk
bind hs_ctrl hs_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.input_level_ok_pin, .high_input_limit_pin, .cond_in, .fet_drive_out, .latched_trip_pin);

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for hs_ctrl
// Assumes: restart count cut to 50
// Notes: one task per scenario
`timescale 1ns/1ps
`include "hs_ctrl_defines.svh"
module tb_top;
	import hs_ctrl_pkg::*;
	localparam int unsigned RC = 50;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, b;
	logic ok = 1'b1;
	logic hi = 1'b0;
	logic allow = 1'b1;
	stat_t cond = '0;
	logic fet, good, trip, p1, p2;
	int mismatches = 0;
	int tests_run = 0;
	// 20 MHz
	always #25 pclk = ~pclk;
	hs_ctrl #(.RESTART_CYCLES(RC)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .input_level_ok_pin(ok), .high_input_limit_pin(hi), .output_sense_pin(fet),
		.sm_allow_on(allow), .cond_in(cond), .fet_drive_out(fet), .output_good_flag(good),
		.latched_trip_pin(trip), .first_multi_pin(p1), .second_multi_pin(p2));
	bus_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : cmp
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	task automatic io(logic w, logic [11:0] a, logic [31:0] d);
		host.xfer(w, a, d, q, err);
		if (host.hung) begin
			mismatches++;
			final_report();
		end
	endtask : io
	task automatic tick(int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	task automatic t_power();
		tick(6);
		cmp("drive at start", 1, fet);
		io(0, `A_STAT_BYTE, 0);
		b = q;
		cmp("off bit", 0, q[6]);
		io(0, `A_STAT_WORD, 0);
		cmp("word low byte", b[7:0], q[7:0]);
		cmp("word high byte", 0, q[15:8]);
		cmp("output good", 1, good);
		$display("t_power done");
	endtask : t_power
	task automatic t_op();
		io(1, `A_OPERATION, 0);
		tick(2);
		cmp("off cmd", 0, fet);
		io(0, `A_STAT_BYTE, 0);
		cmp("off bit set", 1, q[6]);
		ok <= 1'b0;
		io(1, `A_OPERATION, 32'h80);
		tick(5);
		cmp("low supply", 0, fet);
		ok <= 1'b1;
		hi <= 1'b1;
		tick(5);
		cmp("over limit", 0, fet);
		hi <= 1'b0;
		io(1, `A_CLEAR, 0);
		tick(5);
		cmp("drive back", 1, fet);
		$display("t_op done");
	endtask : t_op
	task automatic t_fault();
		cond.uv_fault <= 1'b1;
		tick(6);
		cmp("trip", 1, trip);
		cmp("drive cut", 0, fet);
		cmp("good dropped", 0, good);
		cond.uv_fault <= 1'b0;
		tick(6);
		io(0, `A_STAT_BYTE, 0);
		cmp("uv latched", 1, q[3]);
		io(1, `A_CLEAR, 0);
		tick(3);
		io(0, `A_STAT_BYTE, 0);
		cmp("uv cleared", 0, q[3]);
		cond.ov_fault <= 1'b1;
		tick(6);
		io(1, `A_CLEAR, 0);
		io(0, `A_STAT_BYTE, 0);
		cmp("ov kept", 1, q[5]);
		cond.ov_fault <= 1'b0;
		tick(6);
		io(1, `A_OPERATION, 0);
		io(1, `A_OPERATION, 32'h80);
		tick(4);
		cmp("trip freed", 0, trip);
		io(0, `A_STAT_BYTE, 0);
		cmp("ov freed", 0, q[5]);
		$display("t_fault done");
	endtask : t_fault
	task automatic t_restart();
		int n;
		io(1, `A_RESTART, 1);
		tick(2);
		n = 0;
		while (!fet && n < 4 * RC) begin
			tick(1);
			n++;
		end
		cmp("back on", 1, fet);
		cmp("off time", RC, n);
		$display("t_restart done");
	endtask : t_restart
	task automatic t_pins();
		io(1, `A_MASK1, 32'h4); // ot_warn is bit 2
		cond.ot_warn <= 1'b1;
		io(1, `A_SETUP, 32'h10);
		tick(5);
		cmp("gpo1", 1, p1);
		cmp("gpo2", 0, p2);
		io(1, `A_SETUP, 32'h01);
		tick(3);
		cmp("alert1", 0, p1);
		io(1, `A_SETUP, 32'h02);
		tick(3);
		cmp("comparator high", 1, p1);
		cond.ot_warn <= 1'b0;
		tick(5);
		cmp("comparator low", 0, p1);
		io(1, `A_MASK1, 32'h400);
		io(1, `A_MASK2, 32'h400);
		io(1, `A_SETUP, 32'h05);
		io(1, `A_CLEAR, 0);
		cond.uv_fault <= 1'b1;
		tick(6);
		cmp("fault alert2", 0, p2);
		cmp("no fault alert1", 1, p1);
		cond.uv_fault <= 1'b0;
		io(1, `A_OPERATION, 0);
		io(1, `A_OPERATION, 32'h80);
		tick(5);
		$display("t_pins done");
	endtask : t_pins
	task automatic t_info();
		io(0, `A_CAPABILITY, 0);
		cmp("capability", {24'h0, `CAPABILITY_VAL}, q);
		io(1, `A_ID_IDX, 0);
		io(0, `A_ID_DATA, 0);
		cmp("id count", {24'h0, `ID_LEN}, q);
		io(1, `A_ID_IDX, 1);
		io(0, `A_ID_DATA, 0);
		cmp("id text", 1, q >= 32'h20 && q <= 32'h7e);
		io(0, 12'h0fc, 0);
		cmp("unmapped", 1, err);
		io(1, `A_CMD_FRAME, 32'h100);
		tick(3);
		cmp("bad frame skipped", 1, fet);
		io(0, `A_STAT_BYTE, 0);
		cmp("comm flag", 1, q[1]);
		io(1, `A_CMD_FRAME, 32'h200);
		tick(3);
		cmp("group held", 1, fet);
		io(0, `A_COMM, 0);
		cmp("group pending", 1, q[0]);
		io(1, `A_CMD_FRAME, 32'h480);
		tick(3);
		cmp("group on stop", 0, fet);
		io(0, `A_COMM, 0);
		cmp("group done", 0, q[0]);
		io(1, `A_OPERATION, 32'h80);
		tick(3);
		cmp("on after group", 1, fet);
		$display("t_info done");
	endtask : t_info
	// main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_power();
		t_op();
		t_fault();
		t_restart();
		t_pins();
		t_info();
		final_report();
	end
endmodule : tb_top

// ==== verilog/hs_ctrl.sv ====
// Purpose: command interpreter and status of a hot swap controller
// Assumes: pins come from outside pclk, conditions are levels
// Notes: commands arrive as APB writes; group frames via A_CMD_FRAME
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "hs_ctrl_defines.svh"
module hs_ctrl #(
	parameter int unsigned RESTART_CYCLES = `RESTART_SEC * `CLK_HZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic input_level_ok_pin,
	input wire logic high_input_limit_pin,
	input wire logic output_sense_pin,
	input wire logic sm_allow_on,
	input wire hs_ctrl_pkg::stat_t cond_in,
	output logic fet_drive_out,
	output logic output_good_flag,
	output logic latched_trip_pin,
	output logic first_multi_pin,
	output logic second_multi_pin
);
	import hs_ctrl_pkg::*;

	// pin synchronisers: first stage read only by second
	logic [2:0] pin_s1_r, pin_s2_r;
	stat_t cond_s1_r, cond_s2_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// idle levels: supply ok, no overvoltage, so no false fault after reset
			pin_s1_r <= `PIN_IDLE;
			pin_s2_r <= `PIN_IDLE;
			cond_s1_r <= '0;
			cond_s2_r <= '0;
		end else begin
			pin_s1_r <= {output_sense_pin, high_input_limit_pin, input_level_ok_pin};
			pin_s2_r <= pin_s1_r;
			cond_s1_r <= cond_in;
			cond_s2_r <= cond_s1_r;
		end
	end
	wire uv_ok = pin_s2_r[0];
	wire ov_hi = pin_s2_r[1];
	wire out_sense = pin_s2_r[2];
	wire supply_ok = uv_ok & ~ov_hi;

	// apb decode; zero wait states
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire w_op = wr & (paddr == `A_OPERATION);
	wire w_rst = wr & (paddr == `A_RESTART);
	wire w_clr = wr & (paddr == `A_CLEAR);
	wire w_setup = wr & (paddr == `A_SETUP);
	wire w_m1 = wr & (paddr == `A_MASK1);
	wire w_m2 = wr & (paddr == `A_MASK2);
	wire w_idx = wr & (paddr == `A_ID_IDX);
	wire w_frame = wr & (paddr == `A_CMD_FRAME);
	assign pready = 1'b1;

	// frame: [7:0] data, [8] pec bad, [9] group member, [10] stop, [11] target is restart
	wire fr_pec_bad = pwdata[`FR_PEC];
	wire fr_group = pwdata[`FR_GROUP];
	wire fr_stop = pwdata[`FR_STOP];
	wire fr_is_rst = pwdata[`FR_RST];
	logic [7:0] held_data_r;
	logic held_valid_r, held_rst_r;
	wire fr_ok = w_frame & ~fr_pec_bad;
	wire fr_now = fr_ok & ~fr_group;
	wire rel = w_frame & fr_stop & held_valid_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			held_valid_r <= 1'b0;
			held_data_r <= 8'h00;
			held_rst_r <= 1'b0;
		end else if (fr_ok & fr_group) begin
			held_valid_r <= 1'b1;
			held_data_r <= pwdata[7:0];
			held_rst_r <= fr_is_rst;
		end else if (rel) begin
			held_valid_r <= 1'b0;
		end
	end

	// merged command strobes from direct writes, frames and group release
	wire op_go = w_op | (fr_now & ~fr_is_rst) | (rel & ~held_rst_r);
	wire rst_go = w_rst | (fr_now & fr_is_rst) | (rel & held_rst_r);
	wire [7:0] op_val = w_op ? pwdata[7:0] : (rel ? held_data_r : pwdata[7:0]);

	// on bit; toggling 0 then 1 clears latched faults
	logic on_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_r <= 1'(`ON_RESET >> `ON_BIT);
		end else if (op_go) begin
			on_r <= op_val[`ON_BIT];
		end
	end
	wire toggle_clr = op_go & ~on_r & op_val[`ON_BIT];
	wire any_clr = toggle_clr | w_clr;

	// timed restart
	restart_t rs_r;
	logic [31:0] rs_cnt_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rs_r <= ST_IDLE;
			rs_cnt_r <= 32'h0;
		end else begin
			unique case (rs_r)
				ST_IDLE: if (rst_go) begin
					rs_r <= ST_OFF;
					rs_cnt_r <= 32'h0;
				end
				ST_OFF: begin
					rs_cnt_r <= rs_cnt_r + 32'h1;
					if (rs_cnt_r >= RESTART_CYCLES - 1) rs_r <= ST_DONE;
				end
				ST_DONE: rs_r <= ST_IDLE;
				default: rs_r <= ST_IDLE;
			endcase
		end
	end
	wire rs_off = (rs_r == ST_OFF);

	// latched status; set beats clear, live condition re-sets at once
	stat_t cond_live, lat_r;
	always_comb begin
		cond_live = cond_s2_r;
		cond_live.uv_fault = cond_s2_r.uv_fault | ~uv_ok;
		cond_live.ov_fault = cond_s2_r.ov_fault | ov_hi;
		cond_live.comm_err = 1'b0;
	end
	wire pec_evt = w_frame & fr_pec_bad;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) lat_r <= '0;
		else begin
			lat_r <= (any_clr ? '0 : lat_r) | cond_live;
			if (pec_evt | (lat_r.comm_err & ~any_clr)) lat_r.comm_err <= 1'b1;
			else lat_r.comm_err <= 1'b0;
		end
	end
	wire any_fault = lat_r.cl_timeout | lat_r.ov_fault | lat_r.uv_fault | lat_r.ot_fault | lat_r.fet_fault;
	wire any_warn = lat_r.vin_ov_warn | lat_r.vin_uv_warn | lat_r.vout_ov_warn | lat_r.vout_uv_warn
		| lat_r.iout_oc_warn | lat_r.ot_warn | lat_r.pin_op_warn;

	// gate drive: every off cause wins over the on request
	// each off cause kept as its own wire so the priority is easy to read
	wire req_on = on_r;
	wire supply_allows = supply_ok;
	wire hold_off = rs_off | any_fault;
	// warnings are not part of hold_off: they never touch the drive
	wire drive_nxt = req_on & supply_allows & sm_allow_on & ~hold_off;
	logic drive_r, good_r, trip_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_r <= 1'b0;
			good_r <= 1'b0;
			trip_r <= 1'b0;
		end else begin
			drive_r <= drive_nxt;
			good_r <= drive_nxt & out_sense;
			trip_r <= any_fault;
		end
	end
	assign fet_drive_out = drive_r;
	assign output_good_flag = good_r;
	assign latched_trip_pin = trip_r;

	// detailed status bytes
	wire [7:0] s_input = {lat_r.vin_ov_warn, lat_r.vin_uv_warn, lat_r.ov_fault, lat_r.uv_fault,
		lat_r.pin_op_warn, 3'h0};
	wire [7:0] s_vout = {1'b0, lat_r.vout_ov_warn, lat_r.vout_uv_warn, 5'h0};
	wire [7:0] s_iout = {1'b0, lat_r.cl_timeout, lat_r.iout_oc_warn, 5'h0};
	wire [7:0] s_temp = {lat_r.ot_fault, lat_r.ot_warn, 6'h0};
	wire [7:0] s_mfr = {7'h0, lat_r.fet_fault};
	// summary: off, ov, oc, uv, temp, cml, none_of_above
	wire [7:0] s_byte = {1'b0, ~drive_r, lat_r.ov_fault, lat_r.cl_timeout, lat_r.uv_fault,
		lat_r.ot_fault | lat_r.ot_warn, lat_r.comm_err, any_fault | any_warn};
	wire [7:0] s_high = {|s_vout, |s_iout, |s_input, |s_mfr, ~good_r, lat_r.fet_fault, 2'h0};
	wire [15:0] s_word = {s_high, s_byte};

	// configuration: mode per pin and gpo level
	logic [1:0] mode1_r, mode2_r;
	logic gpo1_r, gpo2_r;
	logic [15:0] mask1_r, mask2_r;
	logic [1:0] idx_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode1_r <= `MODE_GPO;
			mode2_r <= `MODE_GPO;
			gpo1_r <= 1'b0;
			gpo2_r <= 1'b0;
			mask1_r <= 16'h0000;
			mask2_r <= 16'h0000;
			idx_r <= 2'h0;
		end else begin
			if (w_setup) begin
				mode1_r <= pwdata[1:0];
				mode2_r <= pwdata[3:2];
				gpo1_r <= pwdata[4];
				gpo2_r <= pwdata[5];
			end
			if (w_m1) mask1_r <= pwdata[15:0];
			if (w_m2) mask2_r <= pwdata[15:0];
			if (w_idx) idx_r <= pwdata[1:0];
		end
	end

	// mask bits map to stat_t fields 12:0; faults in [12:8] only on pin two in alert mode
	wire [15:0] lat_v = {3'h0, lat_r};
	wire [15:0] live_v = {3'h0, cond_live};
	wire [15:0] warn_only = 16'h00ff;
	wire al1 = |(lat_v & mask1_r & warn_only);
	wire al2 = |(lat_v & mask2_r);
	wire cp1 = |(live_v & mask1_r & warn_only);
	wire cp2 = |(live_v & mask2_r & warn_only);
	function automatic logic pin_sel(input logic [1:0] m, input logic g, input logic a, input logic c);
		pin_sel = (m == `MODE_ALERT) ? ~a : ((m == `MODE_CMP) ? c : g);
	endfunction : pin_sel
	logic p1_r, p2_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p1_r <= 1'b0;
			p2_r <= 1'b0;
		end else begin
			p1_r <= pin_sel(mode1_r, gpo1_r, al1, cp1);
			p2_r <= pin_sel(mode2_r, gpo2_r, al2, cp2);
		end
	end
	assign first_multi_pin = p1_r;
	assign second_multi_pin = p2_r;

	// identity string: index 0 is the count, then characters
	wire [7:0] id_byte = (idx_r == 2'h0) ? `ID_LEN : 8'h41 + {6'h0, idx_r};

	// read mux
	// address map membership; anything else answers with an error
	function automatic logic is_mapped(input logic [11:0] a);
		unique case (a)
			`A_OPERATION,
			`A_RESTART,
			`A_CLEAR,
			`A_STAT_BYTE,
			`A_STAT_WORD,
			`A_STAT_INPUT,
			`A_STAT_VOUT,
			`A_STAT_IOUT,
			`A_STAT_TEMP,
			`A_STAT_MFR,
			`A_SETUP,
			`A_MASK1,
			`A_MASK2,
			`A_CAPABILITY,
			`A_ID_IDX,
			`A_ID_DATA,
			`A_COMM,
			`A_CMD_FRAME: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped
	wire hit_r = is_mapped(paddr);
	logic [31:0] rd;
	always_comb begin
		unique case (paddr)
			`A_OPERATION: rd = {24'h0, on_r, 7'h0};
			`A_STAT_BYTE: rd = {24'h0, s_byte};
			`A_STAT_WORD: rd = {16'h0, s_word};
			`A_STAT_INPUT: rd = {24'h0, s_input};
			`A_STAT_VOUT: rd = {24'h0, s_vout};
			`A_STAT_IOUT: rd = {24'h0, s_iout};
			`A_STAT_TEMP: rd = {24'h0, s_temp};
			`A_STAT_MFR: rd = {24'h0, s_mfr};
			`A_SETUP: rd = {26'h0, gpo2_r, gpo1_r, mode2_r, mode1_r};
			`A_MASK1: rd = {16'h0, mask1_r};
			`A_MASK2: rd = {16'h0, mask2_r};
			`A_CAPABILITY: rd = {24'h0, `CAPABILITY_VAL};
			`A_ID_IDX: rd = {30'h0, idx_r};
			`A_ID_DATA: rd = {24'h0, id_byte};
			`A_COMM: rd = {31'h0, held_valid_r};
			default: rd = 32'h0;
		endcase
	end
	assign prdata = rd;
	assign pslverr = acc & ~hit_r;
endmodule : hs_ctrl
